// ==== inc/sar_adc_pkg.sv ====
package sar_adc_pkg;

    // ---------------------------------------------------------------
    // bus geometry
    // ---------------------------------------------------------------
    localparam int unsigned ADR_W  = 8;
    localparam int unsigned DAT_W  = 32;
    localparam int unsigned SEL_W  = 4;

    // ---------------------------------------------------------------
    // register byte offsets
    // ---------------------------------------------------------------
    localparam logic [7:0] OFS_STATUS   = 8'h00;
    localparam logic [7:0] OFS_RES_HIGH = 8'h04;
    localparam logic [7:0] OFS_RES_LOW  = 8'h08;
    localparam logic [7:0] OFS_CLK_CFG  = 8'h0c;
    localparam logic [7:0] OFS_PORT_DAT = 8'h10;
    localparam logic [7:0] OFS_PORT_DIR = 8'h14;
    localparam logic [7:0] OFS_PORT_PIN = 8'h18;

    // ---------------------------------------------------------------
    // field positions and codes
    // ---------------------------------------------------------------
    localparam int unsigned STS_DONE_BIT = 7;
    localparam int unsigned STS_IRQ_BIT  = 6;
    localparam int unsigned STS_CONT_BIT = 5;
    localparam int unsigned CH_W         = 5;
    localparam int unsigned CFG_DIV_LSB  = 5;
    localparam int unsigned CFG_SRC_BIT  = 4;
    localparam int unsigned CFG_MODE_LSB = 2;
    localparam int unsigned NUM_PINS     = 8;
    localparam int unsigned RES_W        = 10;
    localparam logic [4:0]  CH_REF_HIGH  = 5'h1d;
    localparam logic [4:0]  CH_REF_LOW   = 5'h1e;
    localparam logic [4:0]  CH_OFF       = 5'h1f;

    // ---------------------------------------------------------------
    // reset values and timing counts (converter clock ticks)
    // ---------------------------------------------------------------
    localparam logic [7:0] STS_RST      = 8'h1f;
    localparam logic [7:0] CFG_RST      = 8'h00;
    localparam logic [3:0] SAMPLE_TICKS = 4'h2;
    localparam logic [3:0] CONV_TICKS   = 4'hf;
    localparam logic [9:0] RES_FULL     = 10'h3ff;
    localparam logic [9:0] RES_ZERO     = 10'h000;
    localparam logic [9:0] TRIAL_FIRST  = 10'h200;

    typedef enum logic [1:0] {
        JUST_LEFT        = 2'b00,
        JUST_RIGHT       = 2'b01,
        JUST_LEFT_SIGNED = 2'b10,
        JUST_TRUNC8      = 2'b11
    } justify_t;

    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_SAMPLE = 2'b01,
        ST_APPROX = 2'b10,
        ST_FINISH = 2'b11
    } conv_state_t;

    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [7:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } wb_req_t;

    typedef struct packed {
        logic [31:0] dat;
        logic        ack;
    } wb_rsp_t;

    typedef struct packed {
        logic       power_on;
        logic       sample;
        logic [4:0] mux_sel;
        logic [9:0] dac_code;
    } afe_ctrl_t;

endpackage

// ==== src/sar_adc_sequencer.sv ====
`timescale 1ns/10ps
module sar_adc_sequencer (
    // clock and reset
    input  wire logic                 clk,
    input  wire logic                 rst,
    // wishbone slave
    input  sar_adc_pkg::wb_req_t      wb_i,
    output sar_adc_pkg::wb_rsp_t      wb_o,
    // analog front end
    output sar_adc_pkg::afe_ctrl_t    afe_o,
    input  wire logic                 cmp_in,
    // shared port pins
    input  wire logic [7:0]           pin_in,
    output logic      [7:0]           pin_out,
    output logic      [7:0]           pin_oe_n,
    // system
    input  wire logic                 stop_mode,
    output logic                      irq
);

    // ---------------------------------------------------------------
    // bus decode
    // ---------------------------------------------------------------
    logic ack_q;
    logic acc;
    logic wr_en;
    logic rd_en;
    logic wr_status;
    logic wr_cfg;
    logic wr_pdat;
    logic wr_pdir;
    logic rd_high;
    logic rd_low;
    logic rd_result;

    assign acc       = wb_i.cyc & wb_i.stb & ~ack_q;
    assign wr_en     = acc & wb_i.we & wb_i.sel[0];
    assign rd_en     = acc & ~wb_i.we;
    assign wr_status = wr_en & (wb_i.adr == sar_adc_pkg::OFS_STATUS);
    assign wr_cfg    = wr_en & (wb_i.adr == sar_adc_pkg::OFS_CLK_CFG);
    assign wr_pdat   = wr_en & (wb_i.adr == sar_adc_pkg::OFS_PORT_DAT);
    assign wr_pdir   = wr_en & (wb_i.adr == sar_adc_pkg::OFS_PORT_DIR);
    assign rd_high   = rd_en & (wb_i.adr == sar_adc_pkg::OFS_RES_HIGH);
    assign rd_low    = rd_en & (wb_i.adr == sar_adc_pkg::OFS_RES_LOW);
    assign rd_result = rd_high | rd_low;

    // ---------------------------------------------------------------
    // control registers
    // ---------------------------------------------------------------
    logic                 irq_en_q;
    logic                 cont_q;
    logic [4:0]           chan_q;
    logic [2:0]           div_q;
    logic                 src_q;
    sar_adc_pkg::justify_t mode_q;
    logic [4:0]           wr_chan;
    logic                 powered;

    assign wr_chan = wb_i.dat[4:0];
    assign powered = (chan_q != sar_adc_pkg::CH_OFF);

    always_ff @(posedge clk) begin
        if (rst) begin
            irq_en_q <= sar_adc_pkg::STS_RST[sar_adc_pkg::STS_IRQ_BIT];
            cont_q   <= sar_adc_pkg::STS_RST[sar_adc_pkg::STS_CONT_BIT];
            chan_q   <= sar_adc_pkg::STS_RST[4:0];
        end else if (wr_status) begin
            irq_en_q <= wb_i.dat[sar_adc_pkg::STS_IRQ_BIT];
            cont_q   <= wb_i.dat[sar_adc_pkg::STS_CONT_BIT];
            chan_q   <= wr_chan;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            div_q  <= sar_adc_pkg::CFG_RST[7:5];
            src_q  <= sar_adc_pkg::CFG_RST[sar_adc_pkg::CFG_SRC_BIT];
            mode_q <= sar_adc_pkg::justify_t'(sar_adc_pkg::CFG_RST[3:2]);
        end else if (wr_cfg) begin
            div_q  <= wb_i.dat[7:5];
            src_q  <= wb_i.dat[sar_adc_pkg::CFG_SRC_BIT];
            mode_q <= sar_adc_pkg::justify_t'(wb_i.dat[3:2]);
        end
    end

    // ---------------------------------------------------------------
    // converter clock tick
    // ---------------------------------------------------------------
    logic [3:0] div_cnt_q;
    logic [3:0] div_mask;
    logic       tick;

    always_comb begin
        div_mask = 4'h0;
        if (div_q[2]) begin
            div_mask = 4'hf;
        end else begin
            case (div_q[1:0])
                2'b00:   div_mask = 4'h0;
                2'b01:   div_mask = 4'h1;
                2'b10:   div_mask = 4'h3;
                default: div_mask = 4'h7;
            endcase
        end
    end

    // free running, so a start lands anywhere inside a tick period
    assign tick = ((div_cnt_q | ~div_mask) == 4'hf);

    always_ff @(posedge clk) begin
        if (rst) begin
            div_cnt_q <= 4'h0;
        end else begin
            div_cnt_q <= div_cnt_q + 4'h1;
        end
    end

    // ---------------------------------------------------------------
    // conversion sequencer
    // ---------------------------------------------------------------
    sar_adc_pkg::conv_state_t state_q;
    logic [3:0] step_q;
    logic [3:0] bit_q;
    logic [9:0] trial_q;
    logic       pending_q;
    logic       conv_end;
    logic       halt;

    assign halt     = stop_mode | ~powered;
    assign conv_end = (state_q == sar_adc_pkg::ST_FINISH) & tick
                      & (step_q == sar_adc_pkg::CONV_TICKS);

    // request stays pending through stop mode so the run restarts from sampling after it
    always_ff @(posedge clk) begin
        if (rst) begin
            pending_q <= 1'b0;
        end else if (wr_status) begin
            pending_q <= (wr_chan != sar_adc_pkg::CH_OFF);
        end else if (conv_end & ~cont_q) begin
            pending_q <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_q <= sar_adc_pkg::ST_IDLE;
        end else if (wr_status) begin
            // a write restarts any conversion in flight, or ends it when it selects CH_OFF or stop_mode is high
            state_q <= (wr_chan != sar_adc_pkg::CH_OFF) & ~stop_mode
                       ? sar_adc_pkg::ST_SAMPLE : sar_adc_pkg::ST_IDLE;
        end else if (halt) begin
            state_q <= sar_adc_pkg::ST_IDLE;
        end else begin
            case (state_q)
                sar_adc_pkg::ST_IDLE: begin
                    if (pending_q) begin
                        state_q <= sar_adc_pkg::ST_SAMPLE;
                    end
                end
                sar_adc_pkg::ST_SAMPLE: begin
                    if (tick & (step_q == sar_adc_pkg::SAMPLE_TICKS - 4'h1)) begin
                        state_q <= sar_adc_pkg::ST_APPROX;
                    end
                end
                sar_adc_pkg::ST_APPROX: begin
                    if (tick & (bit_q == 4'h0)) begin
                        state_q <= sar_adc_pkg::ST_FINISH;
                    end
                end
                sar_adc_pkg::ST_FINISH: begin
                    if (conv_end) begin
                        state_q <= cont_q ? sar_adc_pkg::ST_SAMPLE
                                          : sar_adc_pkg::ST_IDLE;
                    end
                end
                default: state_q <= sar_adc_pkg::ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst | wr_status | halt | (state_q == sar_adc_pkg::ST_IDLE) | conv_end) begin
            step_q <= 4'h0;
        end else if (tick) begin
            step_q <= step_q + 4'h1;
        end
    end

    // successive approximation: keep the trial bit when input is at or above it;
    // the next trial also loads the dac register so the comparator never lags a tick
    logic [9:0] trial_d;
    logic [3:0] bit_d;

    always_comb begin
        trial_d = trial_q;
        bit_d   = bit_q;
        if (state_q == sar_adc_pkg::ST_SAMPLE) begin
            trial_d = sar_adc_pkg::TRIAL_FIRST;
            bit_d   = 4'h9;
        end else if ((state_q == sar_adc_pkg::ST_APPROX) & tick) begin
            trial_d[bit_q] = cmp_in;
            if (bit_q != 4'h0) begin
                trial_d[bit_q - 4'h1] = 1'b1;
                bit_d = bit_q - 4'h1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            trial_q <= sar_adc_pkg::RES_ZERO;
            bit_q   <= 4'h9;
        end else begin
            trial_q <= trial_d;
            bit_q   <= bit_d;
        end
    end

    // ---------------------------------------------------------------
    // result formatting and interlock
    // ---------------------------------------------------------------
    logic [7:0] res_hi_q;
    logic [7:0] res_lo_q;
    logic       hold_q;
    logic [7:0] fmt_hi;
    logic [7:0] fmt_lo;

    always_comb begin
        fmt_hi = 8'h00;
        fmt_lo = 8'h00;
        case (mode_q)
            sar_adc_pkg::JUST_LEFT: begin
                fmt_hi = trial_q[9:2];
                fmt_lo = {trial_q[1:0], 6'h00};
            end
            sar_adc_pkg::JUST_RIGHT: begin
                fmt_hi = {6'h00, trial_q[9:8]};
                fmt_lo = trial_q[7:0];
            end
            sar_adc_pkg::JUST_LEFT_SIGNED: begin
                fmt_hi = {~trial_q[9], trial_q[8:2]};
                fmt_lo = {trial_q[1:0], 6'h00};
            end
            default: begin
                fmt_hi = 8'h00;
                fmt_lo = trial_q[9:2];
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            hold_q <= 1'b0;
        end else if (rd_low) begin
            hold_q <= 1'b0;
        end else if (rd_high & (mode_q != sar_adc_pkg::JUST_TRUNC8)) begin
            hold_q <= 1'b1;
        end
    end

    // results only change at a conversion end, with the mode in force then
    always_ff @(posedge clk) begin
        if (rst) begin
            res_hi_q <= 8'h00;
            res_lo_q <= 8'h00;
        end else if (conv_end & ~(hold_q & (mode_q != sar_adc_pkg::JUST_TRUNC8))) begin
            res_hi_q <= fmt_hi;
            res_lo_q <= fmt_lo;
        end
    end

    // ---------------------------------------------------------------
    // completion flag and interrupt
    // ---------------------------------------------------------------
    logic done_q;
    logic irq_q;

    always_ff @(posedge clk) begin
        if (rst) begin
            done_q <= 1'b0;
        end else if (conv_end & ~irq_en_q) begin
            done_q <= 1'b1;
        end else if (rd_result) begin
            done_q <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            irq_q <= 1'b0;
        end else if (conv_end & irq_en_q) begin
            irq_q <= 1'b1;
        end else if (rd_result | wr_status) begin
            irq_q <= 1'b0;
        end
    end

    // also serves as the wake request while the processor waits
    assign irq = irq_q;

    // ---------------------------------------------------------------
    // shared port pins
    // ---------------------------------------------------------------
    logic [7:0] pin_meta_q;
    logic [7:0] pin_sync_q;
    logic [7:0] pdat_q;
    logic [7:0] pdir_q;
    logic [7:0] taken;
    logic [7:0] port_rd;

    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_pin
            assign taken[gi] = (chan_q == 5'(gi));
            assign port_rd[gi] = taken[gi] ? 1'b0
                               : (pdir_q[gi] ? pdat_q[gi] : pin_sync_q[gi]);
            always_ff @(posedge clk) begin
                if (rst) begin
                    pdat_q[gi] <= 1'b0;
                    pdir_q[gi] <= 1'b0;
                end else if (~taken[gi]) begin
                    if (wr_pdat) begin
                        pdat_q[gi] <= wb_i.dat[gi];
                    end
                    if (wr_pdir) begin
                        pdir_q[gi] <= wb_i.dat[gi];
                    end
                end
            end
            always_ff @(posedge clk) begin
                if (rst) begin
                    pin_out[gi]  <= 1'b0;
                    pin_oe_n[gi] <= 1'b1;
                end else begin
                    pin_out[gi]  <= pdat_q[gi] & ~taken[gi];
                    pin_oe_n[gi] <= ~(pdir_q[gi] & ~taken[gi]);
                end
            end
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (rst) begin
            pin_meta_q <= 8'h00;
            pin_sync_q <= 8'h00;
        end else begin
            pin_meta_q <= pin_in;
            pin_sync_q <= pin_meta_q;
        end
    end

    // ---------------------------------------------------------------
    // analog front end control
    // ---------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            afe_o <= '0;
            afe_o.mux_sel <= sar_adc_pkg::CH_OFF;
        end else begin
            afe_o.power_on <= powered & ~stop_mode;
            afe_o.sample   <= (state_q == sar_adc_pkg::ST_SAMPLE);
            afe_o.mux_sel  <= chan_q;
            afe_o.dac_code <= trial_d;
        end
    end

    // ---------------------------------------------------------------
    // read data and acknowledge
    // ---------------------------------------------------------------
    logic [7:0]  rd_byte;
    logic [31:0] rd_dat_q;

    always_comb begin
        rd_byte = 8'h00;
        case (wb_i.adr)
            sar_adc_pkg::OFS_STATUS:   rd_byte = {done_q & ~irq_en_q,
                                                  irq_en_q, cont_q, chan_q};
            sar_adc_pkg::OFS_RES_HIGH: rd_byte = res_hi_q;
            sar_adc_pkg::OFS_RES_LOW:  rd_byte = res_lo_q;
            sar_adc_pkg::OFS_CLK_CFG:  rd_byte = {div_q, src_q, mode_q, 2'b00};
            sar_adc_pkg::OFS_PORT_DAT: rd_byte = pdat_q;
            sar_adc_pkg::OFS_PORT_DIR: rd_byte = pdir_q;
            sar_adc_pkg::OFS_PORT_PIN: rd_byte = port_rd;
            default:                   rd_byte = 8'h00;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ack_q    <= 1'b0;
            rd_dat_q <= '0;
        end else begin
            ack_q <= acc;
            if (rd_en) begin
                rd_dat_q <= {24'h000000, rd_byte};
            end
        end
    end

    assign wb_o = '{dat: rd_dat_q, ack: ack_q};

endmodule

// ==== tb/afe_model.sv ====
`timescale 1ns/10ps
module afe_model (
    // clock
    input  wire logic               clk,
    // converter control and sources
    input  sar_adc_pkg::afe_ctrl_t  afe_o,
    input  wire logic [79:0]        ain,
    output logic                    cmp_in
);
    logic [9:0] vin;
    logic       idle_q = 1'h0;
    // references give the two ends of the scale
    always_comb begin
        case (afe_o.mux_sel)
            5'h1d:   vin = 10'h3ff;
            5'h1e:   vin = 10'h000;
            default: vin = ain[afe_o.mux_sel[2:0] * 10 +: 10];
        endcase
    end
    // unpowered comparator output wanders
    always_ff @(posedge clk) begin
        idle_q <= ~idle_q;
    end
    assign cmp_in = afe_o.power_on ? (vin >= afe_o.dac_code) : idle_q;
endmodule

// ==== tb/sar_adc_sequencer_assertions.sv ====
`timescale 1ns/10ps
module sar_adc_sequencer_assertions (
    // clock and reset
    input  wire logic               clk,
    input  wire logic               rst,
    // bus and front end
    input  sar_adc_pkg::wb_req_t    wb_i,
    input  sar_adc_pkg::wb_rsp_t    wb_o,
    input  sar_adc_pkg::afe_ctrl_t  afe_o,
    input  wire logic               cmp_in,
    // pins and system
    input  wire logic [7:0]         pin_in,
    input  wire logic [7:0]         pin_out,
    input  wire logic [7:0]         pin_oe_n,
    input  wire logic               stop_mode,
    input  wire logic               irq
);
    logic [2:0] pn;
    assign pn = afe_o.mux_sel[2:0];
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    a_ack_single: assert property (wb_o.ack |=> !wb_o.ack)
        else $error("ack held too long");
    a_ack_answer: assert property (wb_i.cyc && wb_i.stb && !wb_o.ack |=> wb_o.ack)
        else $error("request not answered next cycle");
    a_upper_zero: assert property (wb_o.ack |-> wb_o.dat[31:8] == 24'h0)
        else $error("upper read bits not zero");
    a_taken_input: assert property (
        afe_o.mux_sel < 5'h08 && $stable(afe_o.mux_sel) |-> pin_oe_n[pn] && !pin_out[pn])
        else $error("taken pin still driven");
    a_off_unpowered: assert property (
        afe_o.mux_sel == 5'h1f && $stable(afe_o.mux_sel) |-> !afe_o.power_on)
        else $error("converter powered while off");
    a_stop_idle: assert property (
        stop_mode [*3] |-> !afe_o.power_on && !afe_o.sample)
        else $error("converter active in stop");
    a_sample_len: assert property ($rose(afe_o.sample) |-> afe_o.sample [*2])
        else $error("sample phase too short");
    a_sample_ends: assert property ($rose(afe_o.sample) |-> ##[1:40] !afe_o.sample)
        else $error("sample phase never ends");
    a_reset_vals: assert property (
        $fell(rst) |-> pin_oe_n == 8'hff && !irq && afe_o.mux_sel == 5'h1f)
        else $error("bad state after reset");
endmodule

// ==== tb/tb.sv ====
`timescale 1ns/10ps
module tb;
    typedef struct packed {
        logic [1:0] mode;
        logic [4:0] ch;
        logic [7:0] hi;
        logic [7:0] lo;
    } row_t;
    logic                   clk = 1'h0;
    logic                   rst = 1'h1;
    sar_adc_pkg::wb_req_t   wb_i = '0;
    sar_adc_pkg::wb_rsp_t   wb_o;
    sar_adc_pkg::afe_ctrl_t afe_o;
    logic                   cmp_in;
    logic [7:0]             pin_in = 8'h5a;
    logic [7:0]             pin_out;
    logic [7:0]             pin_oe_n;
    logic                   stop_mode = 1'h0;
    logic                   irq;
    logic [79:0]            ain = {8{10'h2b6}};
    logic [31:0]            rd;
    int                     n_fail = 0;
    int                     total_checks = 0;
    int                     lat = 0;
    row_t rows [7] = '{'{2'h0, 5'h02, 8'had, 8'h80}, '{2'h1, 5'h05, 8'h02, 8'hb6},
        '{2'h2, 5'h07, 8'h2d, 8'h80}, '{2'h3, 5'h00, 8'h00, 8'had},
        '{2'h1, 5'h1d, 8'h03, 8'hff}, '{2'h1, 5'h1e, 8'h00, 8'h00},
        '{2'h2, 5'h03, 8'hfc, 8'h40}};

    initial begin
        forever #5 clk = ~clk;
    end

    sar_adc_sequencer u_dut (.clk(clk), .rst(rst), .wb_i(wb_i), .wb_o(wb_o), .afe_o(afe_o),
        .cmp_in(cmp_in), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
        .stop_mode(stop_mode), .irq(irq));
    afe_model u_afe (.clk(clk), .afe_o(afe_o), .ain(ain), .cmp_in(cmp_in));

    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    task automatic tally_and_finish;
        $display("checks %0d failures %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH %0t value %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_flag(input logic got, input logic exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH %0t flag %b expected %b", $time, got, exp);
        end
    endtask
    task automatic wb(input logic we, input logic [7:0] a, input logic [7:0] d);
        int n;
        n = 0;
        wb_i <= '{cyc: 1'h1, stb: 1'h1, we: we, adr: a, sel: 4'hf, dat: {24'h0, d}};
        @(posedge clk);
        while (wb_o.ack !== 1'h1 && n < 20) begin
            n++;
            @(posedge clk);
        end
        if (n == 20) begin
            n_fail++;
            $display("MISMATCH %0t no bus answer", $time);
        end
        rd = wb_o.dat;
        wb_i <= '0;
        @(posedge clk);
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        wb(1'h0, a, 8'h00);
        chk_reg(rd[7:0], exp);
    endtask
    task automatic wait_done;
        int k;
        k = 0;
        wb(1'h0, sar_adc_pkg::OFS_STATUS, 8'h00);
        while (rd[7] !== 1'h1 && k < 30) begin
            k++;
            wb(1'h0, sar_adc_pkg::OFS_STATUS, 8'h00);
        end
        if (k == 30) begin
            n_fail++;
            $display("MISMATCH %0t no completion", $time);
        end
    endtask
    task automatic wait_irq;
        lat = 0;
        while (irq !== 1'h1 && lat < 60) begin
            lat++;
            @(posedge clk);
        end
        if (lat == 60) begin
            n_fail++;
            $display("MISMATCH %0t no interrupt", $time);
        end
    endtask

    // ---------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------
    initial begin
        ain[30 +: 10] = 10'h1f1;
        repeat (4) @(posedge clk);
        rst <= 1'h0;
        @(posedge clk);
        rchk(sar_adc_pkg::OFS_STATUS, 8'h1f);
        rchk(sar_adc_pkg::OFS_CLK_CFG, 8'h00);
        rchk(8'h20, 8'h00);
        foreach (rows[i]) begin
            wb(1'h1, sar_adc_pkg::OFS_CLK_CFG, {4'h0, rows[i].mode, 2'h0});
            wb(1'h1, sar_adc_pkg::OFS_STATUS, {3'h0, rows[i].ch});
            wait_done;
            rchk(sar_adc_pkg::OFS_RES_HIGH, rows[i].hi);
            rchk(sar_adc_pkg::OFS_RES_LOW, rows[i].lo);
        end
        repeat (40) @(posedge clk);
        rchk(sar_adc_pkg::OFS_STATUS, 8'h03);
        wb(1'h1, sar_adc_pkg::OFS_PORT_DIR, 8'h0f);
        wb(1'h1, sar_adc_pkg::OFS_PORT_DAT, 8'hff);
        chk_reg(pin_oe_n, 8'hf8);
        chk_reg(pin_out, 8'hf7);
        rchk(sar_adc_pkg::OFS_PORT_PIN, 8'h57);
        wb(1'h1, sar_adc_pkg::OFS_CLK_CFG, 8'h04);
        wb(1'h1, sar_adc_pkg::OFS_STATUS, 8'h22);
        ain[20 +: 10] = 10'h155;
        repeat (40) @(posedge clk);
        rchk(sar_adc_pkg::OFS_RES_HIGH, 8'h01);
        rchk(sar_adc_pkg::OFS_RES_LOW, 8'h55);
        // the run cut short by this write is never read
        wb(1'h1, sar_adc_pkg::OFS_STATUS, 8'h02);
        wait_done;
        wb(1'h1, sar_adc_pkg::OFS_CLK_CFG, 8'h0c);
        rchk(sar_adc_pkg::OFS_RES_HIGH, 8'h01);
        rchk(sar_adc_pkg::OFS_RES_LOW, 8'h55);
        wb(1'h1, sar_adc_pkg::OFS_CLK_CFG, 8'h00);
        wb(1'h1, sar_adc_pkg::OFS_STATUS, 8'h02);
        wait_done;
        rchk(sar_adc_pkg::OFS_RES_HIGH, 8'h55);
        ain[20 +: 10] = 10'h2b6;
        wb(1'h1, sar_adc_pkg::OFS_STATUS, 8'h02);
        repeat (40) @(posedge clk);
        rchk(sar_adc_pkg::OFS_RES_LOW, 8'h40);
        rchk(sar_adc_pkg::OFS_RES_HIGH, 8'h55);
        rchk(sar_adc_pkg::OFS_RES_LOW, 8'h40);
        wb(1'h1, sar_adc_pkg::OFS_STATUS, 8'h42);
        wait_irq;
        chk_flag(irq, 1'h1);
        chk_flag(lat >= 15 && lat <= 16, 1'h1);
        rchk(sar_adc_pkg::OFS_STATUS, 8'h42);
        wb(1'h0, sar_adc_pkg::OFS_RES_LOW, 8'h00);
        chk_flag(irq, 1'h0);
        wb(1'h1, sar_adc_pkg::OFS_STATUS, 8'h42);
        wait_irq;
        wb(1'h1, sar_adc_pkg::OFS_STATUS, 8'h5f);
        chk_flag(irq, 1'h0);
        wb(1'h1, sar_adc_pkg::OFS_CLK_CFG, 8'h34);
        rchk(sar_adc_pkg::OFS_CLK_CFG, 8'h34);
        wb(1'h1, sar_adc_pkg::OFS_STATUS, 8'h02);
        repeat (8) @(posedge clk);
        stop_mode <= 1'h1;
        repeat (20) @(posedge clk);
        rchk(sar_adc_pkg::OFS_STATUS, 8'h02);
        stop_mode <= 1'h0;
        wait_done;
        rchk(sar_adc_pkg::OFS_RES_HIGH, 8'h02);
        rchk(sar_adc_pkg::OFS_RES_LOW, 8'hb6);
        // reset after the run has finished returns the block to its idle state
        rst <= 1'h1;
        repeat (4) @(posedge clk);
        rst <= 1'h0;
        @(posedge clk);
        chk_reg(pin_oe_n, 8'hff);
        chk_flag(irq, 1'h0);
        rchk(sar_adc_pkg::OFS_STATUS, 8'h1f);
        tally_and_finish;
    end

    initial begin
        #100000;
        n_fail++;
        tally_and_finish;
    end
endmodule

bind sar_adc_sequencer sar_adc_sequencer_assertions u_chk (.clk(clk), .rst(rst),
    .wb_i(wb_i), .wb_o(wb_o), .afe_o(afe_o), .cmp_in(cmp_in), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe_n(pin_oe_n), .stop_mode(stop_mode), .irq(irq));
